// ### core/pin_sync.sv
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import timer_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    typedef struct packed {
        logic [2:0] sh;
        logic lvl;
        logic rise;
        logic fall;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.sh = {st_q.sh[1:0], i_pin};
        st_d.rise = 1'b0;
        st_d.fall = 1'b0;
        // second and third stage agree before the level moves
        if (st_q.sh[1] == st_q.sh[2] && st_q.sh[2] != st_q.lvl) begin
            st_d.lvl = st_q.sh[2];
            st_d.rise = st_q.sh[2];
            st_d.fall = ~st_q.sh[2];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.lvl;
    assign o_rise = st_q.rise;
    assign o_fall = st_q.fall;
endmodule
`default_nettype wire

// ### core/prescaler.sv
// prescaler: divides tick pulses by 1, 8, 64 or 256
`timescale 1ns/1ps
`default_nettype none
module prescaler
    import timer_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [1:0] i_select,
    output logic o_tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic out;
    } ps_state_t;

    ps_state_t st_q;
    ps_state_t st_d;

    function automatic logic [7:0] ps_limit(input logic [1:0] sel);
        case (sel)
            2'h0: ps_limit = PS_DIV1;
            2'h1: ps_limit = PS_DIV8;
            2'h2: ps_limit = PS_DIV64;
            default: ps_limit = PS_DIV256;
        endcase
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.out = 1'b0;
        if (i_run) begin
            if (i_clear) begin
                st_d.cnt = 8'h00;
            end else if (i_tick) begin
                if (st_q.cnt >= ps_limit(i_select)) begin
                    st_d.cnt = 8'h00;
                    st_d.out = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt + 8'h01;
                end
            end
        end
        // run clear: a clearing event leaves the count alone
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_tick = st_q.out;
endmodule
`default_nettype wire

// ### core/sixteen_bit_timer_rtc.sv
// top: 16-bit timer/counter with rtc mode and apb register slave
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_rtc
    import timer_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_cpu_idle,
    input wire logic i_cpu_sleep,
    input wire logic i_external_clock_gate_pin,
    input wire logic i_lp_osc_clk,
    output logic o_irq,
    output logic o_wake
);
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] period;
        logic [15:0] control;
        logic [15:0] osc;
        logic [IRQ_BITS-1:0] status;
        logic [IRQ_BITS-1:0] mask;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
        logic wake;
        logic ctl_changed;
    } top_state_t;

    top_state_t st_q;
    top_state_t st_d;
    apb_req_t req;
    cpu_state_t cpu;

    logic ext_level;
    logic ext_rise;
    logic ext_fall;
    logic osc_rise;
    logic ps_tick;
    logic ps_clear;
    logic raw_tick;
    logic run;
    logic cs_ext;
    logic sync_sel;
    logic gate_en;
    logic lp_en;
    logic halted;
    logic access;
    logic wr;
    logic match;

    function automatic logic addr_hit(input logic [11:0] a,
                                      input logic [11:0] reg_addr);
        addr_hit = (a == reg_addr);
    endfunction

    assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                   paddr: i_paddr, pwdata: i_pwdata};
    assign cpu = '{idle: i_cpu_idle, sleep: i_cpu_sleep};

    pin_sync u_ext_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_external_clock_gate_pin),
        .o_level(ext_level),
        .o_rise(ext_rise),
        .o_fall(ext_fall)
    );

    pin_sync u_osc_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_lp_osc_clk),
        .o_level(),
        .o_rise(osc_rise),
        .o_fall()
    );

    assign run = st_q.control[CTL_RUN];
    assign cs_ext = st_q.control[CTL_CS];
    assign sync_sel = st_q.control[CTL_SYNC];
    assign gate_en = st_q.control[CTL_GATE];
    assign lp_en = st_q.osc[OSC_LP_EN];
    assign access = req.psel & req.penable & st_q.ready;
    assign wr = access & req.pwrite;
    assign ps_clear = wr & (addr_hit(req.paddr, ADDR_COUNT) |
                            addr_hit(req.paddr, ADDR_CONTROL));

    // stop conditions for idle and sleep
    always_comb begin
        halted = 1'b0;
        if (cpu.idle && st_q.control[CTL_IDLE_STOP]) begin
            halted = 1'b1;
        end
        if (cpu.sleep) begin
            // only async external counting (rtc included) survives, and only until control or osc is written in sleep
            halted = !(cs_ext && !sync_sel) || st_q.ctl_changed;
        end
    end

    // selection of the count source
    always_comb begin
        raw_tick = 1'b0;
        if (lp_en) begin
            // rtc source replaces the normal timer and counter modes
            if (cs_ext && !gate_en) begin
                raw_tick = osc_rise;
            end
        end else if (cs_ext) begin
            raw_tick = ext_rise;
        end else if (gate_en) begin
            raw_tick = ext_level;
        end else begin
            raw_tick = 1'b1;
        end
        if (halted) begin
            raw_tick = 1'b0;
        end
    end

    prescaler u_prescaler (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_run(run),
        .i_clear(ps_clear),
        .i_tick(raw_tick),
        .i_select(st_q.control[CTL_PS_HI:CTL_PS_LO]),
        .o_tick(ps_tick)
    );

    assign match = run && ps_tick && (st_q.count == st_q.period);

    always_comb begin
        st_d = st_q;
        st_d.ready = 1'b0;
        st_d.err = 1'b0;
        // count advance, held while run is clear
        if (run && ps_tick) begin
            if (match) begin
                st_d.count = COUNT_RESET;
            end else begin
                st_d.count = st_q.count + 16'h0001;
            end
        end
        // bus access phase answers one cycle after penable rises
        if (req.psel && req.penable && !st_q.ready) begin
            st_d.ready = 1'b1;
            st_d.rdata = 32'h0000_0000;
            case (req.paddr)
                ADDR_COUNT: st_d.rdata = {16'h0000, st_q.count};
                ADDR_PERIOD: st_d.rdata = {16'h0000, st_q.period};
                ADDR_CONTROL: st_d.rdata = {16'h0000, st_q.control};
                ADDR_OSC: st_d.rdata = {16'h0000, st_q.osc};
                ADDR_IRQ_STATUS: st_d.rdata = {29'h0, st_q.status};
                ADDR_IRQ_MASK: st_d.rdata = {29'h0, st_q.mask};
                default: st_d.err = 1'b1;
            endcase
        end
        if (wr) begin
            case (req.paddr)
                ADDR_COUNT: st_d.count = req.pwdata[15:0];
                ADDR_PERIOD: st_d.period = req.pwdata[15:0];
                ADDR_CONTROL: begin
                    st_d.control = req.pwdata[15:0] & CONTROL_WMASK;
                    st_d.ctl_changed = 1'b1;
                end
                ADDR_OSC: begin
                    st_d.osc = req.pwdata[15:0] & (16'h0001 << OSC_LP_EN);
                    st_d.ctl_changed = 1'b1;
                end
                ADDR_IRQ_STATUS: st_d.status = st_q.status &
                                               ~req.pwdata[IRQ_BITS-1:0];
                ADDR_IRQ_MASK: st_d.mask = req.pwdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
        if (!cpu.sleep) begin
            st_d.ctl_changed = 1'b0;
        end
        // events set sticky bits after any clear, so the set wins
        if (match) begin
            st_d.status[IRQ_MATCH] = 1'b1;
            if (lp_en) begin
                st_d.status[IRQ_WAKE] = 1'b1;
            end
        end
        if (run && gate_en && !cs_ext && ext_fall && !halted) begin
            st_d.status[IRQ_GATE] = 1'b1;
        end
        st_d.irq = |(st_d.status & st_d.mask);
        st_d.wake = st_d.status[IRQ_WAKE] & st_d.mask[IRQ_WAKE];
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= '0;
            st_q.count <= COUNT_RESET;
            st_q.period <= PERIOD_RESET;
            st_q.control <= CONTROL_RESET;
            st_q.osc <= OSC_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_prdata = st_q.rdata;
    assign o_pready = st_q.ready;
    assign o_pslverr = st_q.err;
    assign o_irq = st_q.irq;
    assign o_wake = st_q.wake;
endmodule
`default_nettype wire

// ### core/timer_pkg.sv
// package: register map, fields, reset values and bus types of the timer
package timer_pkg;
    localparam logic [11:0] ADDR_COUNT = 12'h100;
    localparam logic [11:0] ADDR_PERIOD = 12'h104;
    localparam logic [11:0] ADDR_CONTROL = 12'h108;
    localparam logic [11:0] ADDR_OSC = 12'h10C;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h110;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h114;
    localparam int CTL_RUN = 15;
    localparam int CTL_IDLE_STOP = 13;
    localparam int CTL_GATE = 6;
    localparam int CTL_PS_HI = 5;
    localparam int CTL_PS_LO = 4;
    localparam int CTL_SYNC = 2;
    localparam int CTL_CS = 1;
    localparam int OSC_LP_EN = 1;
    localparam logic [15:0] CONTROL_WMASK = 16'hA076;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] OSC_RESET = 16'h0000;
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_GATE = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_BITS = 3;
    localparam logic [7:0] PS_DIV1 = 8'h00;
    localparam logic [7:0] PS_DIV8 = 8'h07;
    localparam logic [7:0] PS_DIV64 = 8'h3F;
    localparam logic [7:0] PS_DIV256 = 8'hFF;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic idle;
        logic sleep;
    } cpu_state_t;
endpackage

// ### tb/pin_source.sv
// far-side model: external clock or gate pin and low-power oscillator
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    input wire logic i_clk,
    output logic o_pin,
    output logic o_osc
);
    initial begin
        o_pin = 1'b0;
        o_osc = 1'b0;
    end
    // both lines rest low between bursts; oscillator rate scaled down
    task automatic pulses(input logic osc, input int n, input int half);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            if (osc) o_osc <= 1'b1; else o_pin <= 1'b1;
            repeat (half) @(posedge i_clk);
            if (osc) o_osc <= 1'b0; else o_pin <= 1'b0;
            repeat (half) @(posedge i_clk);
        end
    endtask
    task automatic gate(input int n);
        @(posedge i_clk);
        o_pin <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench: register, mode and interrupt tests of the timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import timer_pkg::*;
    apb_req_t req;
    logic i_clk, i_arst_n, idle, sleep, pready, pslverr, irq, wake;
    logic pin, osc, err;
    logic [31:0] prdata, rd, c0;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    sixteen_bit_timer_rtc uut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_psel(req.psel), .i_penable(req.penable), .i_pwrite(req.pwrite),
        .i_paddr(req.paddr), .i_pwdata(req.pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cpu_idle(idle),
        .i_cpu_sleep(sleep), .i_external_clock_gate_pin(pin),
        .i_lp_osc_clk(osc), .o_irq(irq), .o_wake(wake));
    pin_source src (.i_clk(i_clk), .o_pin(pin), .o_osc(osc));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors = num_errors + 1;
            results();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge i_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_clk);
        req.penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '{1'b0, 1'b0, w, a, d};
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rng(input logic [31:0] got, input int lo, input int hi);
        tests_run++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("mismatch %0t: %h not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [15:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, {16'h0, e});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        req = '0;
        idle = 1'b0;
        sleep = 1'b0;
        i_arst_n = 1'b0;
        wt(16);
        i_arst_n <= 1'b1;
        rdc(ADDR_COUNT, COUNT_RESET);
        rdc(ADDR_PERIOD, PERIOD_RESET);
        rdc(ADDR_CONTROL, CONTROL_RESET);
        rdc(ADDR_OSC, OSC_RESET);
        rdc(ADDR_IRQ_STATUS, 16'h0);
        rdc(ADDR_IRQ_MASK, 16'h0);
        rdc(12'h118, 16'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, ADDR_PERIOD, 32'h9);
        rdc(ADDR_PERIOD, 16'h0009);
        apb(1'b1, ADDR_CONTROL, 32'h8000);
        wt(30);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        rng(rd, 0, 9);
        c0 = rd;
        apb(1'b1, ADDR_CONTROL, 32'h0074);
        rdc(ADDR_COUNT, c0[15:0]);
        rdc(ADDR_CONTROL, 16'h0074);
        rdc(ADDR_IRQ_STATUS, 16'h0001);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        wt(2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        wt(2);
        chk({31'h0, irq}, 32'h0);
        rdc(ADDR_IRQ_STATUS, 16'h0);
        $display("test match done");
        apb(1'b1, ADDR_PERIOD, 32'hFFFF);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, ADDR_COUNT, 32'h0);
            apb(1'b1, ADDR_CONTROL, 32'h8000 | (32'(p) << 4));
            wt(510);
            apb(1'b1, ADDR_CONTROL, 32'h0);
            apb(1'b0, ADDR_COUNT, 32'h0);
            rng(rd, (512 >> (3 * p)) - 1, (512 >> (3 * p)) + 3);
        end
        $display("test prescale done");
        apb(1'b1, ADDR_CONTROL, 32'hA000);
        idle <= 1'b1;
        wt(4);
        apb(1'b0, ADDR_COUNT, 32'h0);
        c0 = rd;
        wt(20);
        rdc(ADDR_COUNT, c0[15:0]);
        idle <= 1'b0;
        wt(20);
        apb(1'b0, ADDR_COUNT, 32'h0);
        rng(rd, int'(c0) + 20, int'(c0) + 24);
        idle <= 1'b1;
        wt(4);
        apb(1'b0, ADDR_COUNT, 32'h0);
        c0 = rd;
        apb(1'b1, ADDR_CONTROL, 32'h8000);
        wt(20);
        apb(1'b0, ADDR_COUNT, 32'h0);
        rng(rd, int'(c0) + 20, int'(c0) + 34);
        idle <= 1'b0;
        sleep <= 1'b1;
        wt(4);
        apb(1'b0, ADDR_COUNT, 32'h0);
        c0 = rd;
        wt(20);
        rdc(ADDR_COUNT, c0[15:0]);
        sleep <= 1'b0;
        $display("test idle done");
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h8006);
        src.pulses(1'b0, 5, 8);
        rdc(ADDR_COUNT, 16'h0005);
        apb(1'b1, ADDR_CONTROL, 32'h8002);
        sleep <= 1'b1;
        src.pulses(1'b0, 5, 8);
        rdc(ADDR_COUNT, 16'h000A);
        sleep <= 1'b0;
        apb(1'b1, ADDR_CONTROL, 32'h8006);
        sleep <= 1'b1;
        src.pulses(1'b0, 5, 8);
        rdc(ADDR_COUNT, 16'h000A);
        sleep <= 1'b0;
        apb(1'b1, ADDR_CONTROL, 32'hA002);
        idle <= 1'b1;
        src.pulses(1'b0, 3, 8);
        rdc(ADDR_COUNT, 16'h000A);
        idle <= 1'b0;
        $display("test counter done");
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
        apb(1'b1, ADDR_CONTROL, 32'h8040);
        src.gate(40);
        wt(8);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        rng(rd, 38, 42);
        rdc(ADDR_IRQ_STATUS, 16'h0002);
        $display("test gate done");
        apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
        apb(1'b1, ADDR_PERIOD, 32'h3);
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_OSC, 32'h2);
        apb(1'b1, ADDR_IRQ_MASK, 32'h4);
        apb(1'b1, ADDR_CONTROL, 32'h8002);
        sleep <= 1'b1;
        src.pulses(1'b1, 5, 20);
        wt(8);
        rdc(ADDR_COUNT, 16'h0001);
        rdc(ADDR_IRQ_STATUS, 16'h0005);
        chk({31'h0, wake}, 32'h1);
        src.pulses(1'b0, 3, 8);
        rdc(ADDR_COUNT, 16'h0001);
        apb(1'b1, ADDR_CONTROL, 32'h8002);
        src.pulses(1'b1, 2, 20);
        rdc(ADDR_COUNT, 16'h0001);
        sleep <= 1'b0;
        apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
        wt(2);
        chk({31'h0, wake}, 32'h0);
        $display("test rtc done");
        results();
    end
endmodule
bind sixteen_bit_timer_rtc timer_properties chk (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_irq(o_irq), .o_wake(o_wake));
`default_nettype wire

// ### tb/timer_properties.sv
// checker: bus and interrupt relations at the timer ports
`timescale 1ns/1ps
`default_nettype none
module timer_properties
    import timer_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_irq,
    input wire logic o_wake
);
    logic acc, req, mapped;
    logic [15:0] per_q;
    logic [2:0] msk_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    assign acc = i_psel && i_penable && o_pready && !o_pslverr;
    assign req = i_psel && i_penable && !o_pready;
    assign mapped = i_paddr inside {ADDR_COUNT, ADDR_PERIOD,
        ADDR_CONTROL, ADDR_OSC, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
    // shadows of period and mask as software wrote them
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            per_q <= PERIOD_RESET;
            msk_q <= 3'h0;
        end else if (acc && i_pwrite && i_paddr == ADDR_PERIOD) begin
            per_q <= i_pwdata[15:0];
        end else if (acc && i_pwrite && i_paddr == ADDR_IRQ_MASK) begin
            msk_q <= i_pwdata[2:0];
        end
    end
    property p_answer; req |=> o_pready; endproperty
    property p_pulse; o_pready |=> !o_pready; endproperty
    property p_refuse;
        req && !mapped |=> o_pslverr && o_prdata == 32'h0;
    endproperty
    property p_upper;
        req && mapped |=> !o_pslverr && o_prdata[31:16] == 16'h0;
    endproperty
    property p_period;
        acc && !i_pwrite && i_paddr == ADDR_PERIOD |-> o_prdata[15:0] == per_q;
    endproperty
    property p_ctl;
        acc && !i_pwrite && i_paddr == ADDR_CONTROL
            |-> (o_prdata[15:0] & ~CONTROL_WMASK) == 16'h0;
    endproperty
    property p_masked; (msk_q == 3'h0) [*2] |-> !o_irq; endproperty
    // wake and mask move together on the edge that writes the mask
    property p_wake;
        o_wake |-> o_irq && msk_q[IRQ_WAKE];
    endproperty
    a_answer: assert property (p_answer) else $error("no ready");
    a_pulse: assert property (p_pulse) else $error("long ready");
    a_refuse: assert property (p_refuse) else $error("no error");
    a_upper: assert property (p_upper) else $error("bad upper");
    a_period: assert property (p_period) else $error("period");
    a_ctl: assert property (p_ctl) else $error("control bits");
    a_masked: assert property (p_masked) else $error("masked irq");
    a_wake: assert property (p_wake) else $error("wake");
    c_ctl: cover property (acc && i_pwrite && i_paddr == ADDR_CONTROL);
    c_irq: cover property (o_irq);
    c_wake: cover property (o_wake);
endmodule
`default_nettype wire
